// ### hw/phase_pulse_pkg.sv
package phase_pulse_pkg;

  // ----------------------------------------------------------------
  // Phase distribution
  // ----------------------------------------------------------------
  localparam int unsigned MAX_PHASES = 6;
  localparam int unsigned PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PTR_RESET = 3'h0;
  localparam logic [PHASE_W-1:0] COUNT_RESET = 3'h1;
  localparam int unsigned INTERLEAVE_DEG = 360;

  // ----------------------------------------------------------------
  // Load-line settings
  // ----------------------------------------------------------------
  localparam int unsigned DROOP_A_W = 6;
  localparam int unsigned DROOP_B_W = 4;
  localparam int unsigned DROOP_A_OPTIONS = 64;
  localparam int unsigned DROOP_B_OPTIONS = 16;
  localparam int unsigned DROOP_A_MAX_UOHM = 3125;
  localparam int unsigned DROOP_B_MAX_UOHM = 875;
  localparam logic [DROOP_A_W-1:0] DROOP_A_RESET = 6'h00;
  localparam logic [DROOP_B_W-1:0] DROOP_B_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Voltage code decode, target in millivolts
  // ----------------------------------------------------------------
  localparam int unsigned VID_W = 8;
  localparam int unsigned MV_W = 12;
  localparam logic [VID_W-1:0] VID_RESET = 8'h00;
  localparam logic [MV_W-1:0] BASE_5MV_MV = 12'h0FA;
  localparam logic [MV_W-1:0] BASE_10MV_MV = 12'h1F4;
  localparam logic [MV_W-1:0] STEP_5MV_MV = 12'h005;
  localparam logic [MV_W-1:0] STEP_10MV_MV = 12'h00A;

endpackage : phase_pulse_pkg

// ### hw/phase_pulse_distributor_vid.sv
`timescale 1ns/1ns
module phase_pulse_distributor_vid (
  input wire logic clk_in, // 250 MHz core clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic cmp_trip_in, // Feedback fell to comp plus ramp
  input wire logic release_hold_in, // Load-release gating, high blocks pulses
  input wire logic [2:0] active_phases_in, // Active phase count, 1..6
  input wire logic droop_a_wr_in, // Load channel A load-line code
  input wire logic [5:0] droop_a_code_in, // Channel A load-line code
  input wire logic droop_b_wr_in, // Load channel B load-line code
  input wire logic [3:0] droop_b_code_in, // Channel B load-line code
  input wire logic vid_wr_in, // Load voltage code and step size
  input wire logic [7:0] vid_code_in, // Voltage code
  input wire logic step_10mv_in, // 1 selects 10 mV step
  output logic on_pulse_request_out, // One-cycle request pulse
  output logic [5:0] phase_pulse_out, // One-hot on-pulse per phase
  output logic [2:0] phase_ptr_out, // Phase that takes the next pulse
  output logic [5:0] droop_a_out, // Channel A load-line setting
  output logic [3:0] droop_b_out, // Channel B load-line setting
  output logic [7:0] vid_code_out, // Stored voltage code
  output logic step_10mv_out, // Stored step size
  output logic [11:0] reference_target_voltage_out // Target in mV
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Out-of-range counts are clamped so the pointer can never leave the phases
  function automatic logic [2:0] clamp_count(input logic [2:0] n);
    logic [2:0] r;
    r = n;
    if (n == 3'h0) begin
      r = 3'h1;
    end else if (n > 3'(phase_pulse_pkg::MAX_PHASES)) begin
      r = 3'(phase_pulse_pkg::MAX_PHASES);
    end
    return r;
  endfunction : clamp_count

  // Step select is active high: 1 picks the 10 mV step with its 500 mV base
  function automatic logic [11:0] decode_vid(input logic [7:0] code, input logic coarse_step);
    logic [11:0] r;
    logic [11:0] idx;
    idx = {4'h0, code} - 12'h001;
    r = 12'h000;
    if (code != 8'h00) begin
      if (coarse_step) begin
        r = phase_pulse_pkg::BASE_10MV_MV + 12'(idx * phase_pulse_pkg::STEP_10MV_MV);
      end else begin
        r = phase_pulse_pkg::BASE_5MV_MV + 12'(idx * phase_pulse_pkg::STEP_5MV_MV);
      end
    end
    return r;
  endfunction : decode_vid

  // ----------------------------------------------------------------
  // Pulse distribution
  // ----------------------------------------------------------------
  logic trip_prev_reg;
  logic trip_prev_next;
  logic req_reg;
  logic req_next;
  logic [5:0] pulse_reg;
  logic [5:0] pulse_next;
  logic [2:0] ptr_reg;
  logic [2:0] ptr_next;
  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic [2:0] count_now;
  logic trip_event;

  always_comb begin
    count_now = clamp_count(active_phases_in);
    trip_prev_next = cmp_trip_in;
    // No minimum spacing: a comparator that trips sooner gets served sooner
    trip_event = cmp_trip_in & ~trip_prev_reg & ~release_hold_in;
    req_next = trip_event;
    count_next = count_now;
    ptr_next = ptr_reg;
    pulse_next = 6'h00;
    if (count_now != count_reg) begin
      ptr_next = phase_pulse_pkg::PTR_RESET;
      // A request in the change cycle goes to the first phase
      if (trip_event) begin
        pulse_next = 6'h01;
        ptr_next = (count_now == 3'h1) ? phase_pulse_pkg::PTR_RESET : 3'h1;
      end
    end else if (trip_event) begin
      pulse_next = 6'(6'h01 << ptr_reg);
      if (ptr_reg >= count_reg - 3'h1) begin
        ptr_next = phase_pulse_pkg::PTR_RESET;
      end else begin
        ptr_next = ptr_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trip_prev_reg <= 1'b0;
      req_reg <= 1'b0;
      pulse_reg <= 6'h00;
      ptr_reg <= phase_pulse_pkg::PTR_RESET;
      count_reg <= phase_pulse_pkg::COUNT_RESET;
    end else begin
      trip_prev_reg <= trip_prev_next;
      req_reg <= req_next;
      pulse_reg <= pulse_next;
      ptr_reg <= ptr_next;
      count_reg <= count_next;
    end
  end

  assign on_pulse_request_out = req_reg;
  assign phase_pulse_out = pulse_reg;
  assign phase_ptr_out = ptr_reg;

  // ----------------------------------------------------------------
  // Load-line and voltage code settings
  // ----------------------------------------------------------------
  logic [5:0] droop_a_reg;
  logic [5:0] droop_a_next;
  logic [3:0] droop_b_reg;
  logic [3:0] droop_b_next;
  logic [7:0] vid_reg;
  logic [7:0] vid_next;
  logic step_reg;
  logic step_next;
  logic [11:0] vref_reg;
  logic [11:0] vref_next;

  always_comb begin
    droop_a_next = droop_a_wr_in ? droop_a_code_in : droop_a_reg;
    droop_b_next = droop_b_wr_in ? droop_b_code_in : droop_b_reg;
    vid_next = vid_wr_in ? vid_code_in : vid_reg;
    step_next = vid_wr_in ? step_10mv_in : step_reg;
    // Decoded from the stored code, so the target trails the stored code by one cycle and a write by two
    vref_next = decode_vid(vid_reg, step_reg);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      droop_a_reg <= phase_pulse_pkg::DROOP_A_RESET;
      droop_b_reg <= phase_pulse_pkg::DROOP_B_RESET;
      vid_reg <= phase_pulse_pkg::VID_RESET;
      step_reg <= 1'b0;
      vref_reg <= 12'h000;
    end else begin
      droop_a_reg <= droop_a_next;
      droop_b_reg <= droop_b_next;
      vid_reg <= vid_next;
      step_reg <= step_next;
      vref_reg <= vref_next;
    end
  end

  assign droop_a_out = droop_a_reg;
  assign droop_b_out = droop_b_reg;
  assign vid_code_out = vid_reg;
  assign step_10mv_out = step_reg;
  assign reference_target_voltage_out = vref_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_trip_gives_request: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (cmp_trip_in && !$past(cmp_trip_in) && !release_hold_in && $past(nrst_in))
      |=> on_pulse_request_out)
    else $error("comparator trip did not raise a request");

  chk_one_pulse_one_phase: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    on_pulse_request_out == $onehot(phase_pulse_out))
    else $error("request and phase pulse disagree");

  chk_single_phase_same: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (on_pulse_request_out && count_reg == 3'h1) |-> phase_pulse_out == 6'h01)
    else $error("single phase mode pulsed another phase");

  chk_cyclic_order: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (trip_event && count_now == count_reg && ptr_reg < count_reg - 3'h1)
      |=> ptr_reg == $past(ptr_reg) + 3'h1 && phase_pulse_out[$past(ptr_reg)])
    else $error("phase order not cyclic");

  chk_droop_a_load: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    droop_a_wr_in |=> droop_a_out == $past(droop_a_code_in))
    else $error("channel A load-line not loaded");

  chk_droop_b_hold: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (!droop_b_wr_in ##1 !droop_b_wr_in) |-> $stable(droop_b_out))
    else $error("channel B load-line changed without write");

  chk_hold_blocks: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    release_hold_in[*2] |=> !on_pulse_request_out && phase_pulse_out == 6'h00)
    else $error("pulse issued during release hold");

  chk_vid_decode: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (vid_wr_in && vid_code_in == 8'h01 && step_10mv_in) |-> ##2
      reference_target_voltage_out == 12'h1F4)
    else $error("code one at 10 mV step is not 500 mV");

  chk_vid_zero: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (vid_wr_in && vid_code_in == 8'h00) |-> ##2 reference_target_voltage_out == 12'h000)
    else $error("code zero is not zero volts");

  chk_ptr_wrap: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ((count_now != count_reg && !trip_event)
      || (trip_event && count_now == count_reg && ptr_reg == count_reg - 3'h1))
      |=> ptr_reg == 3'h0)
    else $error("pointer failed to wrap or clear");

  chk_ptr_range: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ptr_reg < count_reg || (ptr_reg == 3'h0))
    else $error("pointer beyond active phases");

endmodule : phase_pulse_distributor_vid

// ### testbench/phase_stage_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Power stages: count on-pulses, flag two phases firing at once
// ----------------------------------------------------------------
module phase_stage_model (
  input wire logic clk_in, // Core clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic [5:0] phase_pulse_in, // On-pulse per phase
  output int pulse_count_out, // Pulses taken by all stages
  output logic overlap_out // Sticky, set on a non one-hot pulse
);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pulse_count_out <= 0;
      overlap_out <= 1'b0;
    end else begin
      if (phase_pulse_in !== 6'h00) begin
        pulse_count_out <= pulse_count_out + 1;
      end
      if ($countones(phase_pulse_in) > 1) begin
        overlap_out <= 1'b1;
      end
    end
  end
endmodule : phase_stage_model

// ### testbench/phase_pulse_distributor_vid_bench.sv
`timescale 1ns/1ns
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module phase_pulse_distributor_vid_bench;
  logic clk_in = 0, nrst_in = 0, cmp_trip_in = 0, release_hold_in = 0;
  logic [2:0] active_phases_in = 3'h1;
  logic droop_a_wr_in = 0, droop_b_wr_in = 0, vid_wr_in = 0, step_10mv_in = 0;
  logic [5:0] droop_a_code_in = 6'h00;
  logic [3:0] droop_b_code_in = 4'h0;
  logic [7:0] vid_code_in = 8'h00;
  logic on_pulse_request_out, step_10mv_out;
  logic [5:0] phase_pulse_out, droop_a_out;
  logic [2:0] phase_ptr_out;
  logic [3:0] droop_b_out;
  logic [7:0] vid_code_out;
  logic [11:0] reference_target_voltage_out, exp_mv;
  int bad_count = 0, comparisons = 0, stage_count;
  logic overlap;
  // Codes at both table ends, the first step and two mid-range codes
  logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h02, 8'h33, 8'hC9, 8'hFF};
  always #2 clk_in = ~clk_in;
  phase_pulse_distributor_vid dut (.clk_in, .nrst_in, .cmp_trip_in, .release_hold_in,
    .active_phases_in, .droop_a_wr_in, .droop_a_code_in, .droop_b_wr_in, .droop_b_code_in,
    .vid_wr_in, .vid_code_in, .step_10mv_in, .on_pulse_request_out, .phase_pulse_out,
    .phase_ptr_out, .droop_a_out, .droop_b_out, .vid_code_out, .step_10mv_out,
    .reference_target_voltage_out);
  phase_stage_model stages (.clk_in, .nrst_in, .phase_pulse_in(phase_pulse_out),
    .pulse_count_out(stage_count), .overlap_out(overlap));
  // ----------------------------------------------------------------
  // Shared drivers
  // ----------------------------------------------------------------
  task automatic trip(input logic [2:0] ph, input logic hold);
    @(posedge clk_in) #1;
    `CHK(on_pulse_request_out, 1'b0, "request longer than one cycle")
    cmp_trip_in = 1'b1;
    release_hold_in = hold;
    @(posedge clk_in) #1;
    cmp_trip_in = 1'b0;
    release_hold_in = 1'b0;
    `CHK(on_pulse_request_out, ~hold, "request")
    `CHK(phase_pulse_out, hold ? 6'h00 : 6'h01 << ph, "phase pulse")
  endtask : trip
  task automatic set_phases(input logic [2:0] n);
    @(posedge clk_in) #1;
    active_phases_in = n;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK(phase_ptr_out, 3'h0, "pointer not cleared")
  endtask : set_phases
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_single;
    set_phases(3'h1);
    repeat (3) trip(3'h0, 1'b0);
    // A count of zero is taken as one phase
    set_phases(3'h0);
    repeat (2) trip(3'h0, 1'b0);
    $display("test single phase done");
  endtask : t_single
  task automatic t_rotate;
    // Trips at the fastest rate, so early pulses are not lost
    for (int n = 2; n <= 6; n++) begin
      set_phases(n[2:0]);
      for (int k = 0; k <= n; k++) trip(3'(k % n), 1'b0);
    end
    $display("test rotation done");
  endtask : t_rotate
  task automatic t_hold;
    set_phases(3'h3);
    trip(3'h0, 1'b0);
    trip(3'h1, 1'b1);
    `CHK(phase_ptr_out, 3'h1, "pointer moved while held")
    trip(3'h1, 1'b0);
    trip(3'h2, 1'b0);
    set_phases(3'h2);
    trip(3'h0, 1'b0);
    // Pointer stands at 1 here; a trip in the count-change cycle must go to phase 0
    @(posedge clk_in) #1;
    active_phases_in = 3'h4;
    cmp_trip_in = 1'b1;
    @(posedge clk_in) #1;
    cmp_trip_in = 1'b0;
    `CHK({phase_pulse_out, phase_ptr_out}, {6'h01, 3'h1}, "trip in count change")
    $display("test hold and count change done");
  endtask : t_hold
  task automatic t_settings(input logic [7:0] c, input logic s);
    @(posedge clk_in) #1;
    {droop_a_wr_in, droop_b_wr_in, vid_wr_in} = 3'h7;
    droop_a_code_in = c[5:0];
    droop_b_code_in = c[3:0];
    vid_code_in = c;
    step_10mv_in = s;
    @(posedge clk_in) #1;
    {droop_a_wr_in, droop_b_wr_in, vid_wr_in} = 3'h0;
    `CHK(droop_a_out, c[5:0], "load-line A")
    `CHK(droop_b_out, c[3:0], "load-line B")
    `CHK({vid_code_out, step_10mv_out}, {c, s}, "voltage code")
    exp_mv = (c == 8'h00) ? 12'h000 : (s ? 12'h1F4 : 12'h0FA) + (c - 1) * (s ? 10 : 5);
    @(posedge clk_in) #1;
    `CHK(reference_target_voltage_out, exp_mv, "target voltage")
  endtask : t_settings
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    t_single();
    t_rotate();
    t_hold();
    foreach (codes[i]) begin
      t_settings(codes[i], 1'b0);
      t_settings(codes[i], 1'b1);
    end
    $display("test settings done");
    `CHK(overlap, 1'b0, "two phases fired together")
    `CHK(stage_count, 35, "stages saw a wrong pulse count")
    end_sim();
  end
  initial begin
    #(4 * 5000);
    bad_count++;
    end_sim();
  end
endmodule : phase_pulse_distributor_vid_bench
